/* File: src/rx_queue_pointer_defs.svh */
// Offsets, field layout and reset values of the receive queue pointer registers
`ifndef RX_QUEUE_POINTER_DEFS_SVH
`define RX_QUEUE_POINTER_DEFS_SVH

`define SMALL_FREE_QUEUE_END_ADDR      12'h2b4
`define READY_QUEUE_START_ADDR         12'h2b8
`define READY_QUEUE_WRITE_POINTER_ADDR 12'h2bc
`define READY_QUEUE_READ_POINTER_ADDR  12'h2c0
`define READY_QUEUE_END_ADDR           12'h2c4
`define PTR_FIELD_WIDTH                16
`define PTR_WORD_SHIFT                 2
`define PTR_RESET_VALUE                16'h0000
`define UNUSED_READ_VALUE              16'h0000
`define PTR_COUNT                      5

`endif

/* File: src/rx_queue_pointer_pkg.sv */
// Types shared by the receive queue pointer register bank
package rx_queue_pointer_pkg;
	typedef logic [15:0] offset_type;
	typedef struct packed {
		logic        sel;
		logic        wr;
		logic [3:0]  byteLaneEnables;
		logic [11:0] addr;
		logic [31:0] wdata;
	} host_access_type;
	typedef struct packed {
		logic [31:0] smallFreeQueueEnd;
		logic [31:0] readyQueueStart;
		logic [31:0] readyQueueWrite;
		logic [31:0] readyQueueRead;
		logic [31:0] readyQueueEnd;
	} queue_addresses_type;
endpackage

/* File: src/pointer_register.sv */
// One 16-bit queue offset register with its physical address
`timescale 1ns/1ps
`include "rx_queue_pointer_defs.svh"
module pointer_register
	import rx_queue_pointer_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rstn,
	input  wire logic        load,
	input  wire offset_type  newValue,
	input  wire logic [31:0] receiveQueueBase,
	output offset_type       value,
	output logic [31:0]      physAddr
);
	offset_type  value_d;
	logic [31:0] physAddr_d;

	always_comb begin
		value_d = load ? newValue : value;
		physAddr_d = receiveQueueBase + {14'h0000, value_d, 2'h0};
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			value    <= `PTR_RESET_VALUE;
			physAddr <= 32'h0000_0000;
		end else begin
			value    <= value_d;
			physAddr <= physAddr_d;
		end
	end
endmodule

/* File: src/rx_descriptor_queue_pointers.sv */
// Receive descriptor queue pointer registers on the host register port
`timescale 1ns/1ps
`include "rx_queue_pointer_defs.svh"

module rx_descriptor_queue_pointers
	import rx_queue_pointer_pkg::*;
(
	input  wire logic             clk,
	input  wire logic             rstn,
	input  wire host_access_type  hostAccess,
	input  wire logic [31:0]      receiveQueueBase,
	output logic [31:0]           readData,
	output logic                  readValid,
	output queue_addresses_type   queueAddresses
);
	// ----------------------------------------
	// Decode
	// ----------------------------------------
	offset_type  values [`PTR_COUNT];
	logic [31:0] phys   [`PTR_COUNT];
	logic [`PTR_COUNT-1:0] hit;
	logic        accessOk;
	logic [31:0] readData_d;
	logic        readValid_d;

	// All lanes off means the cycle is no access at all
	assign accessOk = hostAccess.sel && (hostAccess.byteLaneEnables != 4'h0);

	always_comb begin
		hit[0] = hostAccess.addr == `SMALL_FREE_QUEUE_END_ADDR;
		hit[1] = hostAccess.addr == `READY_QUEUE_START_ADDR;
		hit[2] = hostAccess.addr == `READY_QUEUE_WRITE_POINTER_ADDR;
		hit[3] = hostAccess.addr == `READY_QUEUE_READ_POINTER_ADDR;
		hit[4] = hostAccess.addr == `READY_QUEUE_END_ADDR;
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	// Any enabled lane loads all 16 bits; upper half dropped
	for (genvar i = 0; i < `PTR_COUNT; i++) begin : g_ptr
		pointer_register u_reg (
			.clk              (clk),
			.rstn             (rstn),
			.load             (accessOk && hostAccess.wr && hit[i]),
			.newValue         (hostAccess.wdata[15:0]),
			.receiveQueueBase (receiveQueueBase),
			.value            (values[i]),
			.physAddr         (phys[i])
		);
	end

	// Outputs already registered inside each pointer
	always_comb begin
		queueAddresses.smallFreeQueueEnd = phys[0];
		queueAddresses.readyQueueStart   = phys[1];
		queueAddresses.readyQueueWrite   = phys[2];
		queueAddresses.readyQueueRead    = phys[3];
		queueAddresses.readyQueueEnd     = phys[4];
	end

	// ----------------------------------------
	// Read path
	// ----------------------------------------
	always_comb begin
		readData_d  = 32'h0000_0000;
		readValid_d = accessOk && !hostAccess.wr;
		for (int k = 0; k < `PTR_COUNT; k++) begin
			if (hit[k]) begin
				readData_d = {`UNUSED_READ_VALUE, values[k]};
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			readData  <= 32'h0000_0000;
			readValid <= 1'b0;
		end else begin
			readData  <= readData_d;
			readValid <= readValid_d;
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	a_write_loads: assert property (@(posedge clk) disable iff (!rstn)
		accessOk && hostAccess.wr && hit[2] |=> values[2] == $past(hostAccess.wdata[15:0]))
		else $error("ready write pointer not loaded");
	a_no_lanes_hold: assert property (@(posedge clk) disable iff (!rstn)
		hostAccess.sel && hostAccess.byteLaneEnables == 4'h0 |=> $stable(values[3]))
		else $error("pointer changed without byte lanes");
	// Address flop sees last cycle's base with this cycle's offset
	a_end_address: assert property (@(posedge clk) disable iff (!rstn)
		$past(rstn) |->
		queueAddresses.readyQueueEnd == $past(receiveQueueBase) + {14'h0000, values[4], 2'h0})
		else $error("ready end address wrong");
	a_small_end_addr: assert property (@(posedge clk) disable iff (!rstn)
		$past(rstn) |->
		queueAddresses.smallFreeQueueEnd == $past(receiveQueueBase) + {14'h0000, values[0], 2'h0})
		else $error("small free end address wrong");
	a_read_upper_zero: assert property (@(posedge clk) disable iff (!rstn)
		readValid |-> readData[31:16] == 16'h0000)
		else $error("unused bits not zero");
	a_read_answer: assert property (@(posedge clk) disable iff (!rstn)
		accessOk && !hostAccess.wr && hit[3] |=> readValid && readData[15:0] == values[3])
		else $error("read pointer readback wrong");
	a_start_readback: assert property (@(posedge clk) disable iff (!rstn)
		accessOk && hostAccess.wr && hit[1] ##2 accessOk && !hostAccess.wr && hit[1]
		|=> readData[15:0] == $past(hostAccess.wdata[15:0], 3))
		else $error("start offset readback wrong");
	a_reset_zero: assert property (@(posedge clk)
		!rstn |=> values[0] == 16'h0000 && values[4] == 16'h0000)
		else $error("pointer not reset to zero");

	// ----------------------------------------
	// Load and hold checks
	// ----------------------------------------
	a_small_end_loads: assert property (@(posedge clk) disable iff (!rstn)
		accessOk && hostAccess.wr && hit[0]
		|=> values[0] == $past(hostAccess.wdata[15:0]))
		else $error("small free end offset not loaded");
	a_start_loads: assert property (@(posedge clk) disable iff (!rstn)
		accessOk && hostAccess.wr && hit[1]
		|=> values[1] == $past(hostAccess.wdata[15:0]))
		else $error("ready start offset not loaded");
	a_read_ptr_loads: assert property (@(posedge clk) disable iff (!rstn)
		accessOk && hostAccess.wr && hit[3]
		|=> values[3] == $past(hostAccess.wdata[15:0]))
		else $error("ready read pointer not loaded");
	a_end_loads: assert property (@(posedge clk) disable iff (!rstn)
		accessOk && hostAccess.wr && hit[4]
		|=> values[4] == $past(hostAccess.wdata[15:0]))
		else $error("ready end offset not loaded");
	a_no_lanes_small: assert property (@(posedge clk) disable iff (!rstn)
		hostAccess.sel && hostAccess.byteLaneEnables == 4'h0
		|=> $stable(values[0]))
		else $error("small free end changed without lanes");
	a_no_lanes_start: assert property (@(posedge clk) disable iff (!rstn)
		hostAccess.sel && hostAccess.byteLaneEnables == 4'h0
		|=> $stable(values[1]))
		else $error("ready start changed without lanes");
	a_no_lanes_write: assert property (@(posedge clk) disable iff (!rstn)
		hostAccess.sel && hostAccess.byteLaneEnables == 4'h0
		|=> $stable(values[2]))
		else $error("ready write changed without lanes");
	a_no_lanes_end: assert property (@(posedge clk) disable iff (!rstn)
		hostAccess.sel && hostAccess.byteLaneEnables == 4'h0
		|=> $stable(values[4]))
		else $error("ready end changed without lanes");
	a_unmapped_hold: assert property (@(posedge clk) disable iff (!rstn)
		accessOk && hostAccess.wr && hit == 5'h00
		|=> $stable(values[0]) && $stable(values[4]))
		else $error("unmapped write changed a pointer");

	// ----------------------------------------
	// Address and read checks
	// ----------------------------------------
	a_start_address: assert property (@(posedge clk) disable iff (!rstn)
		$past(rstn) |->
		queueAddresses.readyQueueStart == $past(receiveQueueBase) + {14'h0000, values[1], 2'h0})
		else $error("ready start address wrong");
	a_write_address: assert property (@(posedge clk) disable iff (!rstn)
		$past(rstn) |->
		queueAddresses.readyQueueWrite == $past(receiveQueueBase) + {14'h0000, values[2], 2'h0})
		else $error("ready write address wrong");
	a_read_address: assert property (@(posedge clk) disable iff (!rstn)
		$past(rstn) |->
		queueAddresses.readyQueueRead == $past(receiveQueueBase) + {14'h0000, values[3], 2'h0})
		else $error("ready read address wrong");
	a_small_readback: assert property (@(posedge clk) disable iff (!rstn)
		accessOk && !hostAccess.wr && hit[0]
		|=> readValid && readData[15:0] == values[0])
		else $error("small free end readback wrong");
	a_start_read: assert property (@(posedge clk) disable iff (!rstn)
		accessOk && !hostAccess.wr && hit[1]
		|=> readValid && readData[15:0] == values[1])
		else $error("ready start readback wrong");
	a_write_readback: assert property (@(posedge clk) disable iff (!rstn)
		accessOk && !hostAccess.wr && hit[2]
		|=> readValid && readData[15:0] == values[2])
		else $error("ready write readback wrong");
	a_end_readback: assert property (@(posedge clk) disable iff (!rstn)
		accessOk && !hostAccess.wr && hit[4]
		|=> readValid && readData[15:0] == values[4])
		else $error("ready end readback wrong");
	a_unmapped_read: assert property (@(posedge clk) disable iff (!rstn)
		accessOk && !hostAccess.wr && hit == 5'h00
		|=> readValid && readData == 32'h0000_0000)
		else $error("unmapped read not zero");
	a_no_lanes_read: assert property (@(posedge clk) disable iff (!rstn)
		hostAccess.sel && hostAccess.byteLaneEnables == 4'h0
		|=> !readValid)
		else $error("read answered without lanes");
	a_write_silent: assert property (@(posedge clk) disable iff (!rstn)
		hostAccess.sel && hostAccess.wr
		|=> !readValid)
		else $error("write produced read strobe");
	a_valid_cause: assert property (@(posedge clk) disable iff (!rstn)
		readValid
		|-> $past(accessOk && !hostAccess.wr))
		else $error("read strobe without read");
	a_reset_read: assert property (@(posedge clk)
		!rstn
		|=> !readValid && readData == 32'h0000_0000)
		else $error("read port not reset");
	a_reset_address: assert property (@(posedge clk)
		!rstn
		|=> queueAddresses.readyQueueStart == 32'h0000_0000)
		else $error("address not reset");
endmodule

/* File: testbench/rx_descriptor_queue_pointers_tb_top.sv */
// Self-checking bench for the receive queue pointer registers
`timescale 1ns/1ps
`include "rx_queue_pointer_defs.svh"
module rx_descriptor_queue_pointers_tb_top
	import rx_queue_pointer_pkg::*;
;
	logic                clk = 1'b0;
	logic                rstn = 1'b0;
	host_access_type     hostAccess = '0;
	logic [31:0]         receiveQueueBase = 32'h0000_0000;
	logic [31:0]         readData;
	logic                readValid;
	queue_addresses_type queueAddresses;
	int                  bad_count = 0;
	int                  checks_done = 0;
	offset_type          model[5] = '{default: 16'h0000};

	always #12.5 clk = ~clk;

	rx_descriptor_queue_pointers rx_descriptor_queue_pointers_i (
		.clk              (clk),
		.rstn             (rstn),
		.hostAccess       (hostAccess),
		.receiveQueueBase (receiveQueueBase),
		.readData         (readData),
		.readValid        (readValid),
		.queueAddresses   (queueAddresses)
	);

	// ----------------------------------------
	// Expectations and checks
	// ----------------------------------------
	function automatic logic [11:0] addrOf(input int i);
		return `SMALL_FREE_QUEUE_END_ADDR + 12'(4 * i);
	endfunction

	function automatic logic [31:0] phys(input int i);
		return receiveQueueBase + {14'h0000, model[i], 2'b00};
	endfunction

	task automatic chk(input string name, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", name, e, g);
		end
	endtask

	// Request held until its taking edge, then released
	task automatic acc(input logic wr, input logic [11:0] a, input logic [31:0] d,
			input logic [3:0] be);
		@(posedge clk);
		hostAccess <= {1'b1, wr, be, a, d};
		@(posedge clk);
		hostAccess.sel <= 1'b0;
		#1;
	endtask

	task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
		acc(1'b0, a, 32'h0000_0000, 4'hf);
		chk("readValid", 32'h1, {31'h0, readValid});
		chk("readData", e, readData);
	endtask

	task automatic addrchk;
		logic [159:0] q;
		q = queueAddresses;
		for (int i = 0; i < 5; i++) chk("queueAddress", phys(i), q[(4 - i) * 32 +: 32]);
	endtask

	task tally_and_finish;
		if (bad_count == 0 && checks_done > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		int          k;
		logic [31:0] d;
		void'($urandom(42493));
		repeat (6) @(posedge clk);
		rstn <= 1'b1;
		for (int i = 0; i < 5; i++) rdchk(addrOf(i), 32'h0);
		addrchk;
		repeat (40) begin
			k = $urandom % 5;
			d = $urandom;
			@(posedge clk);
			receiveQueueBase <= $urandom;
			acc(1'b1, addrOf(k), d, 4'(($urandom % 15) + 1));
			model[k] = d[15:0];
			// Spacing keeps same-register writes legal and lets addresses settle
			repeat (4) @(posedge clk);
			#1 addrchk;
			rdchk(addrOf(k), {16'h0000, model[k]});
			acc(1'b1, addrOf(k), ~d, 4'h0);
			acc(1'b0, addrOf(k), 32'h0, 4'h0);
			chk("readValid", 32'h0, {31'h0, readValid});
			repeat (4) @(posedge clk);
			rdchk(addrOf(k), {16'h0000, model[k]});
		end
		// Start write then read right behind it
		acc(1'b1, `READY_QUEUE_START_ADDR, d, 4'hf);
		model[1] = d[15:0];
		rdchk(`READY_QUEUE_START_ADDR, {16'h0000, model[1]});
		rdchk(12'h2c8, 32'h0);
		tally_and_finish;
	end

	initial begin
		repeat (4000) @(posedge clk);
		bad_count++;
		tally_and_finish;
	end
endmodule
